/* verification/core_model.sv */
/* Core stand-in: takes vectors after a lag, keeps a stack depth.
   Assumes the bench commands each return through ret_cmd. */
`timescale 1ns/1ps
module core_model #(
    parameter int DEPTH = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic irq_req,
    input wire logic [1:0] lag,
    input wire logic [1:0] ret_cmd,
    output irq_tb_pkg::core_evt_t core_evt,
    output logic stack_full,
    output int acks
);
    int depth; // Return addresses held
    int wait_n; // Cycles the request has waited
    assign stack_full = depth >= DEPTH;
    // Take, then return on command; only the return address is stacked
    always @(posedge clk) begin
        if (!rst_n) begin
            core_evt <= '0;
            depth <= 0;
            wait_n <= 0;
            acks <= 0;
        end else if (irq_req && !stack_full && !core_evt.ack
            && wait_n >= lag) begin
            core_evt <= 3'b100;
            depth <= depth + 1;
            acks <= acks + 1;
            wait_n <= 0;
        end else if (ret_cmd != 2'h0 && depth > 0) begin
            core_evt <= {1'b0, ret_cmd == 2'h1, ret_cmd == 2'h2};
            depth <= depth - 1;
        end else begin
            core_evt <= '0;
            wait_n <= irq_req ? wait_n + 1 : 0;
        end
    end
endmodule // core_model

/* verification/irq_timebase_unit_bench.sv */
/* Self-checking bench for the interrupt and interval unit.
   Assumes the package, design, checker and core model are compiled. */
`timescale 1ns/1ps
module irq_timebase_unit_bench;
    logic clk = 0, rst_n = 0, read = 0, write = 0, sync_byte_done = 0;
    logic sub_clk = 0, waitrequest, irq_req, push_pc_only, wake, stack_full;
    logic [5:0] address = '0;
    logic [31:0] writedata = '0, readdata, q;
    logic [1:0] lag = '0, ret_cmd = '0;
    irq_tb_pkg::uart_evt_t uart_evt = '0;
    irq_tb_pkg::core_evt_t core_evt;
    irq_tb_pkg::vec_t irq_vector;
    int miscompares = 0, total_checks = 0, cyc = 0, wakes = 0, pushes = 0;
    int acks, n, p, t0;
    always #20 clk = ~clk;
    // Cycle count, wake and push tallies, slow subsidiary clock
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (wake === 1'b1) wakes <= wakes + 1;
        if (push_pc_only === 1'b1) pushes <= pushes + 1;
        if (cyc % 3 == 0) sub_clk <= ~sub_clk;
    end
    irq_timebase_unit irq_timebase_unit_inst (.clk(clk), .rst_n(rst_n),
        .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .uart_evt(uart_evt),
        .sync_byte_done(sync_byte_done), .subsidiary_clock(sub_clk),
        .core_evt(core_evt), .stack_full(stack_full), .irq_req(irq_req),
        .irq_vector(irq_vector), .push_pc_only(push_pc_only), .wake(wake));
    core_model core_model_inst (.clk(clk), .rst_n(rst_n),
        .irq_req(irq_req), .lag(lag), .ret_cmd(ret_cmd),
        .core_evt(core_evt), .stack_full(stack_full), .acks(acks));
    task automatic chk(input string s, input logic [31:0] e, g);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Held request until waitrequest low; read data taken at that edge
    task automatic bus(input logic w, input logic [5:0] a,
        input logic [31:0] d);
        int i;
        address <= a;
        writedata <= d;
        read <= !w;
        write <= w;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (waitrequest === 1'b0) break;
        end
        if (i == 20) miscompares++;
        if (i == 20) test_done();
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask
    // Bounded wait on the request (k 0) or a full stack (k 1)
    task automatic wait_on(input int k, input int lim);
        int i;
        for (i = 0; i < lim && (k ? stack_full : irq_req) !== 1'b1; i++)
            @(posedge clk);
        if (i == lim) miscompares++;
        if (i == lim) test_done();
    endtask
    initial begin
        n = $urandom(32'he72c);
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        // Reset values and writable bits of the four registers
        for (int i = 0; i < 4; i++) begin
            p = $urandom;
            bus(0, 6'(i * 4), 0);
            chk("reg reset", 0, q);
            bus(1, 6'(i * 4), p);
            bus(0, 6'(i * 4), 0);
            chk("reg mask", p & (i < 2 ? 32'h03 : 32'h87), q);
            bus(1, 6'(i * 4), 0);
        end
        bus(0, 6'h24, 0);
        chk("unmapped", 0, q);
        bus(1, irq_tb_pkg::ADDR_FLAGS, 32'h1f);
        // Grouped sources: vector, service, full stack, both returns
        for (int s = 0; s < 2; s++) begin
            lag <= 2'($urandom);
            bus(1, irq_tb_pkg::ADDR_ENABLE, 32'h10 | (1 << s));
            bus(1, irq_tb_pkg::ADDR_CORE, 32'h80);
            if (s == 0) uart_evt <= 6'(1 << ($urandom % 6));
            else sync_byte_done <= 1'b1;
            @(posedge clk);
            uart_evt <= '0;
            sync_byte_done <= 1'b0;
            wait_on(0, 20);
            chk("vector", irq_tb_pkg::VEC_GRP, irq_vector);
            wait_on(1, 20);
            bus(0, irq_tb_pkg::ADDR_FLAGS, 0);
            chk("flags", 1 << s, q);
            chk("push", acks, pushes);
            bus(0, irq_tb_pkg::ADDR_CORE, 0);
            chk("global", 0, q);
            bus(1, irq_tb_pkg::ADDR_CORE, 32'h80);
            bus(1, irq_tb_pkg::ADDR_FLAG_SET, 32'h10);
            bus(0, irq_tb_pkg::ADDR_STACK, 0);
            chk("full req", 0, irq_req);
            chk("stack", 1, q[0]);
            bus(1, irq_tb_pkg::ADDR_CORE, 0);
            bus(1, irq_tb_pkg::ADDR_FLAGS, 32'h1f);
            ret_cmd <= 2'(s + 1);
            @(posedge clk);
            ret_cmd <= '0;
            @(posedge clk);
            bus(0, irq_tb_pkg::ADDR_CORE, 0);
            chk("ret global", s ? 0 : 32'h80, q);
            bus(1, irq_tb_pkg::ADDR_CORE, 0);
        end
        // Every serial event wakes with enables clear; preset flags mask
        bus(1, irq_tb_pkg::ADDR_ENABLE, 0);
        for (int b = 0; b < 7; b++) begin
            // The preset is itself a rising flag; let its wake pass
            if (b == 6) begin
                bus(1, irq_tb_pkg::ADDR_FLAG_SET, 32'h1f);
                repeat (2) @(posedge clk);
            end
            p = wakes;
            uart_evt <= 6'(1 << (b % 6));
            @(posedge clk);
            uart_evt <= '0;
            bus(0, irq_tb_pkg::ADDR_FLAGS, 0);
            chk("serial flag", 1, q[0]);
            chk("wake", b < 6, wakes > p);
            bus(1, irq_tb_pkg::ADDR_FLAGS, 32'h1f);
        end
        // Time bases: each source, random period, two overflows each
        for (int t = 0; t < 3; t++) begin
            p = t == 2 ? 2 + $urandom % 2 : t;
            n = $urandom % 3;
            bus(1, 6'((t % 2) * 4), p);
            p = (p > 1 ? 6 : (p == 1 ? 4 : 1)) << (8 + n);
            bus(1, irq_tb_pkg::ADDR_ENABLE, 32'h4 << (t % 2));
            bus(1, irq_tb_pkg::ADDR_CORE, 32'h80);
            t0 = cyc;
            bus(1, 6'(8 + (t % 2) * 4), 32'h80 | n);
            for (int k = 0; k < 2; k++) begin
                wait_on(0, 7000);
                chk("period", 1, cyc - t0 > p - 16 && cyc - t0 < p + 16);
                t0 = cyc;
                chk("tb vec", t % 2 + 1, irq_vector);
                wait_on(1, 20);
                bus(0, irq_tb_pkg::ADDR_FLAGS, 0);
                chk("tb flag", 0, q[2 + t % 2]);
                ret_cmd <= 2'h1;
                @(posedge clk);
                ret_cmd <= '0;
            end
            bus(1, 6'(8 + (t % 2) * 4), 0);
            bus(1, irq_tb_pkg::ADDR_CORE, 0);
            bus(1, irq_tb_pkg::ADDR_FLAGS, 32'h1f);
        end
        test_done();
    end
endmodule // irq_timebase_unit_bench

/* verification/irq_timebase_unit_properties.sv */
/* Port checker for the interrupt and interval unit.
   Assumes one clock and a bind onto irq_timebase_unit. */
`timescale 1ns/1ps
module irq_timebase_unit_properties (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire irq_tb_pkg::core_evt_t core_evt,
    input wire logic stack_full,
    input wire logic irq_req,
    input wire irq_tb_pkg::vec_t irq_vector,
    input wire logic push_pc_only
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Accepted reads of select and control registers
    wire rd_ok = read && !waitrequest;
    wire sel_rd = rd_ok && address[5:3] == 3'b000;
    wire ctl_rd = rd_ok && address[5:3] == 3'b001;
    property p_push; core_evt.ack && irq_req |=> push_pc_only;
    endproperty
    a_push: assert property (p_push) else $error("no push");
    property p_push_once;
        push_pc_only |-> $past(core_evt.ack) ##1 !push_pc_only;
    endproperty
    a_push_once: assert property (p_push_once) else $error("bad push");
    property p_full; stack_full [*3] |-> !irq_req;
    endproperty
    a_full: assert property (p_full) else $error("req on full");
    property p_drop; core_evt.ack && irq_req |-> ##[1:2] !irq_req;
    endproperty
    a_drop: assert property (p_drop) else $error("req kept");
    property p_hold; irq_req && !core_evt.ack && !$past(core_evt.ack)
        && !write && !$past(write) && !stack_full |=> irq_req;
    endproperty
    a_hold: assert property (p_hold) else $error("req lost");
    property p_vec; irq_req |-> irq_vector != irq_tb_pkg::VEC_NONE;
    endproperty
    a_vec: assert property (p_vec) else $error("no vector");
    property p_sel_pad; sel_rd |-> readdata[31:2] == 30'h0;
    endproperty
    a_sel_pad: assert property (p_sel_pad) else $error("sel pad");
    property p_ctl_pad;
        ctl_rd |-> readdata[31:8] == 24'h0 && readdata[6:3] == 4'h0;
    endproperty
    a_ctl_pad: assert property (p_ctl_pad) else $error("ctl pad");
endmodule // irq_timebase_unit_properties
bind irq_timebase_unit irq_timebase_unit_properties props_inst (
    .clk(clk), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .readdata(readdata), .waitrequest(waitrequest),
    .core_evt(core_evt), .stack_full(stack_full), .irq_req(irq_req),
    .irq_vector(irq_vector), .push_pc_only(push_pc_only));

/* verilog/avmm_regs.sv */
/*
 * Avalon-MM slave front end: one wait cycle, then accept.
 * Assumes the master holds requests until waitrequest is low.
 */
`timescale 1ns/1ps
module avmm_regs (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic read,
    input wire logic write,
    output logic waitrequest,
    output logic rd_go,
    output logic wr_go
);
    logic wait_reg; // Low only in the accepting cycle

    // Waitrequest high on first request cycle, low on second
    // Kept as a flop so the bus sees no combinational path
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wait_reg <= 1'b1;
        end else begin
            wait_reg <= !((read || write) && wait_reg);
        end
    end
    assign waitrequest = wait_reg;
    assign rd_go = !wait_reg && read;
    assign wr_go = !wait_reg && write;
endmodule // avmm_regs

/* verilog/interval_timer.sv */
/*
 * One time base: prescaler source select and 2^(8+code) divider.
 * Assumes the subsidiary clock tick is already synchronised.
 */
`timescale 1ns/1ps
module interval_timer #(
    parameter int DIV_W = irq_tb_pkg::DIV_W
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic [1:0] src_sel,
    input wire logic [2:0] period_code,
    input wire logic sys4_tick,
    input wire logic sub_tick,
    output logic overflow
);
    logic [DIV_W-1:0] cnt_reg; // Divider count
    logic [DIV_W-1:0] cnt_next;
    logic tick; // Prescaled clock enable
    logic [DIV_W-1:0] last; // Terminal count of period
    logic ov_reg;

    // Source mux: 00 sys, 01 sys/4, 1x subsidiary
    assign tick = src_sel[1] ? sub_tick :
                  (src_sel == irq_tb_pkg::SRC_SYS4) ? sys4_tick : 1'b1;
    assign last = DIV_W'((32'd1 << (irq_tb_pkg::PERIOD_BASE
                  + 32'(period_code))) - 32'd1);
    assign cnt_next = (cnt_reg >= last) ? '0 : cnt_reg + 1'b1;

    // Count while running, clear when stopped
    always_ff @(posedge clk) begin
        if (!rst_n || !run) begin
            cnt_reg <= '0;
            ov_reg <= 1'b0;
        end else begin
            ov_reg <= 1'b0;
            if (tick) begin
                cnt_reg <= cnt_next;
                ov_reg <= (cnt_reg >= last);
            end
        end
    end
    assign overflow = ov_reg;
endmodule // interval_timer

/* verilog/irq_tb_pkg.sv */
/*
 * Shared constants and types for the interrupt and interval unit.
 * Assumes a single 25 MHz clock and an Avalon-MM register slave.
 */
package irq_tb_pkg;
    // Word byte addresses of the register map
    localparam logic [5:0] ADDR_TB0_CLKSEL = 6'h00;
    localparam logic [5:0] ADDR_TB1_CLKSEL = 6'h04;
    localparam logic [5:0] ADDR_TB0_CTRL = 6'h08;
    localparam logic [5:0] ADDR_TB1_CTRL = 6'h0c;
    localparam logic [5:0] ADDR_ENABLE = 6'h10;
    localparam logic [5:0] ADDR_FLAGS = 6'h14;
    localparam logic [5:0] ADDR_FLAG_SET = 6'h18;
    localparam logic [5:0] ADDR_CORE = 6'h1c;
    localparam logic [5:0] ADDR_STACK = 6'h20;
    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    // Field positions
    localparam int RUN_BIT = 7;
    localparam int PERIOD_LSB = 0;
    localparam int SEL_LSB = 0;
    // Flag / enable bit positions
    localparam int F_SER = 0;
    localparam int F_SYNC = 1;
    localparam int F_TB0 = 2;
    localparam int F_TB1 = 3;
    localparam int F_GRP = 4;
    localparam int NFLAG = 5;
    // Core register: global enable at bit 7; enable register: group enable bit 4
    localparam int E_GLOBAL = 7;
    // Clock source codes
    localparam logic [1:0] SRC_SYS = 2'h0;
    localparam logic [1:0] SRC_SYS4 = 2'h1;
    // Periods start at 2^8
    localparam int PERIOD_BASE = 8;
    localparam int DIV_W = 16;
    localparam logic [1:0] SYS4_LAST = 2'h3;
    // Vector codes
    typedef enum logic [1:0] {VEC_GRP, VEC_TB0, VEC_TB1, VEC_NONE} vec_t;
    // Serial port event group
    typedef struct packed {
        logic tx_empty;
        logic tx_idle;
        logic rx_trigger;
        logic rx_overrun;
        logic addr_detect;
        logic rx_wake;
    } uart_evt_t;
    // Core call/return strobes
    typedef struct packed {
        logic ack;
        logic ret_irq;
        logic ret_plain;
    } core_evt_t;
endpackage

/* verilog/irq_timebase_unit.sv */
/*
 * Interrupt request logic for serial, sync serial and two time bases,
 * with wake-up detection and global enable handling on call/return.
 * Assumes the core pulses ack when it takes the vector, and that the
 * subsidiary clock tick arrives asynchronously on a pin.
 */
`timescale 1ns/1ps
module irq_timebase_unit (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire irq_tb_pkg::uart_evt_t uart_evt,
    input wire logic sync_byte_done,
    input wire logic subsidiary_clock,
    input wire irq_tb_pkg::core_evt_t core_evt,
    input wire logic stack_full,
    output logic irq_req,
    output irq_tb_pkg::vec_t irq_vector,
    output logic push_pc_only,
    output logic wake
);
    localparam int NF = irq_tb_pkg::NFLAG;

    // Register file
    logic [1:0] sel0_reg, sel1_reg; // Prescaler source selects
    logic [7:0] ctl0_reg, ctl1_reg; // Time base control
    logic [NF-1:0] en_reg; // Per-source enables
    logic global_irq_enable_reg;
    logic [NF-1:0] flag_reg, flag_next, flag_prev_reg;
    logic [31:0] rdata_reg;
    logic irq_reg, push_reg, wake_reg;
    irq_tb_pkg::vec_t vec_reg, vec_next;

    // Bus strobes
    logic wr_go, wait_w;
    avmm_regs u_bus (
        .clk(clk),
        .rst_n(rst_n),
        .read(read),
        .write(write),
        .waitrequest(wait_w),
        .rd_go(),
        .wr_go(wr_go)
    );
    assign waitrequest = wait_w;

    // Address decode
    wire wr_sel0 = wr_go && address == irq_tb_pkg::ADDR_TB0_CLKSEL;
    wire wr_sel1 = wr_go && address == irq_tb_pkg::ADDR_TB1_CLKSEL;
    wire wr_ctl0 = wr_go && address == irq_tb_pkg::ADDR_TB0_CTRL;
    wire wr_ctl1 = wr_go && address == irq_tb_pkg::ADDR_TB1_CTRL;
    wire wr_en = wr_go && address == irq_tb_pkg::ADDR_ENABLE;
    wire wr_clr = wr_go && address == irq_tb_pkg::ADDR_FLAGS;
    wire wr_set = wr_go && address == irq_tb_pkg::ADDR_FLAG_SET;
    wire wr_core = wr_go && address == irq_tb_pkg::ADDR_CORE;

    // Subsidiary clock synchroniser and edge tick
    logic sub_s1_reg, sub_s2_reg, sub_s3_reg;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sub_s1_reg <= 1'b0;
            sub_s2_reg <= 1'b0;
            sub_s3_reg <= 1'b0;
        end else begin
            sub_s1_reg <= subsidiary_clock;
            sub_s2_reg <= sub_s1_reg;
            sub_s3_reg <= sub_s2_reg;
        end
    end
    wire sub_tick = sub_s2_reg && !sub_s3_reg;

    // System clock divided by four
    logic [1:0] div4_reg;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div4_reg <= '0;
        end else begin
            div4_reg <= div4_reg + 2'h1;
        end
    end
    wire sys4_tick = div4_reg == irq_tb_pkg::SYS4_LAST;

    // Two time base generators
    logic [1:0] tb_ov;
    logic [1:0] sel_arr [2];
    logic [7:0] ctl_arr [2];
    assign sel_arr[0] = sel0_reg;
    assign sel_arr[1] = sel1_reg;
    assign ctl_arr[0] = ctl0_reg;
    assign ctl_arr[1] = ctl1_reg;
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_tb
            interval_timer u_tb (
                .clk(clk),
                .rst_n(rst_n),
                .run(ctl_arr[g][irq_tb_pkg::RUN_BIT]),
                .src_sel(sel_arr[g]),
                .period_code(ctl_arr[g][irq_tb_pkg::PERIOD_LSB +: 3]),
                .sys4_tick(sys4_tick),
                .sub_tick(sub_tick),
                .overflow(tb_ov[g])
            );
        end
    endgenerate

    // Source events
    wire ser_evt = |uart_evt;
    wire [NF-1:0] src_evt = {1'b0, tb_ov[1], tb_ov[0],
                             sync_byte_done, ser_evt};
    wire grp_evt = (ser_evt && en_reg[irq_tb_pkg::F_SER])
                 || (sync_byte_done && en_reg[irq_tb_pkg::F_SYNC]);

    // Service qualification
    wire grp_ok = flag_reg[irq_tb_pkg::F_GRP] && en_reg[irq_tb_pkg::F_GRP];
    wire tb0_ok = flag_reg[irq_tb_pkg::F_TB0] && en_reg[irq_tb_pkg::F_TB0];
    wire tb1_ok = flag_reg[irq_tb_pkg::F_TB1] && en_reg[irq_tb_pkg::F_TB1];
    wire can_vec = global_irq_enable_reg && !stack_full;
    wire ack = core_evt.ack && irq_reg;

    // Fixed order: group, then time base 0, then time base 1
    always_comb begin
        vec_next = irq_tb_pkg::VEC_NONE;
        if (grp_ok) begin
            vec_next = irq_tb_pkg::VEC_GRP;
        end else if (tb0_ok) begin
            vec_next = irq_tb_pkg::VEC_TB0;
        end else if (tb1_ok) begin
            vec_next = irq_tb_pkg::VEC_TB1;
        end
    end

    // Flag update: sticky, set wins over any clear
    always_comb begin
        flag_next = flag_reg;
        if (wr_clr) begin
            flag_next = flag_next & ~writedata[NF-1:0];
        end
        if (ack) begin
            case (vec_reg)
                irq_tb_pkg::VEC_GRP: flag_next[irq_tb_pkg::F_GRP] = 1'b0;
                irq_tb_pkg::VEC_TB0: flag_next[irq_tb_pkg::F_TB0] = 1'b0;
                irq_tb_pkg::VEC_TB1: flag_next[irq_tb_pkg::F_TB1] = 1'b0;
                default: flag_next = flag_next;
            endcase
        end
        if (wr_set) begin
            flag_next = flag_next | writedata[NF-1:0];
        end
        flag_next = flag_next | src_evt;
        if (grp_evt) begin
            flag_next[irq_tb_pkg::F_GRP] = 1'b1;
        end
    end

    // Configuration and flag registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sel0_reg <= '0;
            sel1_reg <= '0;
            ctl0_reg <= irq_tb_pkg::RST_BYTE;
            ctl1_reg <= irq_tb_pkg::RST_BYTE;
            en_reg <= '0;
            flag_reg <= '0;
            flag_prev_reg <= '0;
        end else begin
            if (wr_sel0) sel0_reg <= writedata[irq_tb_pkg::SEL_LSB +: 2];
            if (wr_sel1) sel1_reg <= writedata[irq_tb_pkg::SEL_LSB +: 2];
            if (wr_ctl0) ctl0_reg <= writedata[7:0] & 8'h87;
            if (wr_ctl1) ctl1_reg <= writedata[7:0] & 8'h87;
            if (wr_en) en_reg <= writedata[NF-1:0];
            flag_reg <= flag_next;
            flag_prev_reg <= flag_reg;
        end
    end

    // Global enable: cleared on entry, restored by interrupt return or by a core register write
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            global_irq_enable_reg <= 1'b0;
        end else if (ack) begin
            global_irq_enable_reg <= 1'b0;
        end else if (core_evt.ret_irq) begin
            global_irq_enable_reg <= 1'b1;
        end else if (core_evt.ret_plain) begin
            global_irq_enable_reg <= global_irq_enable_reg;
        end else if (wr_core) begin
            global_irq_enable_reg <= writedata[irq_tb_pkg::E_GLOBAL];
        end
    end

    // Request, vector, stack push marker and wake outputs
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_reg <= 1'b0;
            vec_reg <= irq_tb_pkg::VEC_NONE;
            push_reg <= 1'b0;
            wake_reg <= 1'b0;
        end else begin
            irq_reg <= can_vec && vec_next != irq_tb_pkg::VEC_NONE && !ack;
            vec_reg <= vec_next;
            push_reg <= ack;
            wake_reg <= |(flag_reg & ~flag_prev_reg);
        end
    end
    assign irq_req = irq_reg;
    assign irq_vector = vec_reg;
    assign push_pc_only = push_reg;
    assign wake = wake_reg;

    // Read mux, unimplemented bits as zero
    logic [31:0] rmux;
    always_comb begin
        case (address)
            irq_tb_pkg::ADDR_TB0_CLKSEL: rmux = {30'h0, sel0_reg};
            irq_tb_pkg::ADDR_TB1_CLKSEL: rmux = {30'h0, sel1_reg};
            irq_tb_pkg::ADDR_TB0_CTRL: rmux = {24'h0, ctl0_reg};
            irq_tb_pkg::ADDR_TB1_CTRL: rmux = {24'h0, ctl1_reg};
            irq_tb_pkg::ADDR_ENABLE: rmux = {27'h0, en_reg};
            irq_tb_pkg::ADDR_FLAGS: rmux = {27'h0, flag_reg};
            irq_tb_pkg::ADDR_CORE: rmux = {24'h0, global_irq_enable_reg,
                                          7'h0};
            irq_tb_pkg::ADDR_STACK: rmux = {31'h0, stack_full};
            default: rmux = 32'h0000_0000;
        endcase
    end
    // Serial status flags are outside this unit; cleared only by the port
    // Captured in the first request cycle so data stand at acceptance
    always_ff @(posedge clk) begin
        if (!rst_n) rdata_reg <= 32'h0000_0000;
        else if (read && wait_w) rdata_reg <= rmux;
    end
    assign readdata = rdata_reg;
endmodule // irq_timebase_unit
